/* link_host.sv */
// serial programmer model driving the link clock and data pin
`default_nettype none
module link_host (
  output var logic sck_o,  // link clock, low outside frames
  output var logic drv_o,  // host drives the data pin
  output var logic dat_o,  // host data value
  input  wire logic line_i // resolved data pin level
);
  timeunit 1ns;
  timeprecision 100ps;
  // idle: clock low, pin released to the pull-up
  initial
  begin
    sck_o = 1'b0;
    drv_o = 1'b0;
    dat_o = 1'b1;
  end
  task automatic frame(input logic wr, input logic tgt, input logic [11:0] a,
                       input logic [13:0] d, output logic [13:0] q);
    logic [27:0] bits;
    bits = {wr, tgt, a, d};
    q = 14'h0000;
    drv_o = 1'b1;
    for (int i = 27; i >= 0; i--)
    begin
      if (i == 13 && !wr)
        drv_o = 1'b0; // device owns the pin for read data
      dat_o = bits[i];
      #80 sck_o = 1'b1;
      if (i < 14 && !wr)
        q[i] = line_i;
      #80 sck_o = 1'b0;
    end
    drv_o = 1'b0;
    // idle long enough for the device to close the frame
    #1200;
  endtask
endmodule // link_host
`default_nettype wire

/* pmem_consts.svh */
// constants for the program memory and table read block
`ifndef PMEM_CONSTS_SVH
`define PMEM_CONSTS_SVH
`define WORD_W        14
`define WORDS_SMALL   1024
`define WORDS_LARGE   2048
`define OFS_W         8
`define TBH_W         8
`define RESET_VEC     12'h000
`define TBLP_RST      8'h00
`define ERASED_WORD   14'h3fff
`define EE_AW_DEF     6
`define SYS_CLK_MHZ   100
`define LINK_IDLE_NS  1000
`define LINK_IDLE_CYC ((`LINK_IDLE_NS * `SYS_CLK_MHZ + 999) / 1000)
`define FRM_CMD_BITS  14
`define FRM_DAT_BITS  14
`define FRM_OP_BIT    13
`define FRM_TGT_BIT   12
`define FRM_ADDR_W    12
`endif

/* pmem_link_if.sv */
// carrier between the serial link engine and the memory core
`default_nettype none
interface pmem_link_if;
  logic        wr_stb;   // one-cycle write strobe
  logic        tgt;      // 1 = eeprom, 0 = program store
  logic [11:0] addr;     // word or byte address
  logic [13:0] wdata;    // write data
  logic [13:0] rd_data;  // read data back to link
  logic        active;   // a frame is in progress
  modport link (output wr_stb, tgt, addr, wdata, active, input rd_data);
  modport core (input wr_stb, tgt, addr, wdata, active, output rd_data);
endinterface
`default_nettype wire

/* pmem_pkg.sv */
// types shared by the program memory block
`default_nettype none
package pmem_pkg;
  typedef enum logic [1:0] {
    TAB_IDLE  = 2'b00,
    TAB_READ  = 2'b01,
    TAB_WRITE = 2'b10
  } tab_state_t;
  typedef enum logic [0:0] {
    PAGE_CURRENT = 1'b0,
    PAGE_LAST    = 1'b1
  } tab_page_t;
  typedef enum logic [1:0] {
    LNK_CMD   = 2'b00,
    LNK_WDATA = 2'b01,
    LNK_RDATA = 2'b10
  } link_state_t;
endpackage
`default_nettype wire

/* prog_store.sv */
// flip-flop program store with fetch, table and link read ports
`default_nettype none
`include "pmem_consts.svh"
module prog_store #(
  parameter int WORDS = `WORDS_SMALL,
  parameter int AW    = $clog2(WORDS)
) (
  input  wire logic          clk_i,    // instruction-cycle clock
  input  wire logic          rstn_i,   // synchronised reset, low
  input  wire logic          we_i,     // program write strobe
  input  wire logic [AW-1:0] waddr_i,  // write word index
  input  wire logic [13:0]   wdata_i,  // write word
  input  wire logic [AW-1:0] faddr_i,  // fetch index
  input  wire logic [AW-1:0] taddr_i,  // table index
  input  wire logic [AW-1:0] laddr_i,  // link read index
  output logic      [13:0]   fdata_o,  // fetch word
  output logic      [13:0]   tdata_o,  // table word
  output logic      [13:0]   ldata_o   // link read word
);
  logic [13:0] mem_reg  [WORDS];
  logic [13:0] mem_next [WORDS];

  // one word written per strobe; reset shows an erased array in simulation
  always_comb
  begin
    mem_next = mem_reg;
    if (we_i)
    begin
      mem_next[waddr_i] = wdata_i;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      for (int i = 0; i < WORDS; i++) mem_reg[i] <= `ERASED_WORD;
    end
    else
    begin
      mem_reg <= mem_next;
    end
  end

  // read ports
  assign fdata_o = mem_reg[faddr_i];
  assign tdata_o = mem_reg[taddr_i];
  assign ldata_o = mem_reg[laddr_i];
endmodule // prog_store
`default_nettype wire

/* program_memory_table_read.sv */
// program store, program counter, table read engine and link top
`default_nettype none
`include "pmem_consts.svh"
module program_memory_table_read #(
  parameter int WORDS      = `WORDS_SMALL,  // store depth
  parameter int EE_AW      = `EE_AW_DEF,    // eeprom address width
  parameter bit EMU_DEVICE = 1'b0,          // emulation part
  localparam int AW = $clog2(WORDS)
) (
  input  wire logic                 sys_clk_i,       // instruction-cycle clock
  input  wire logic                 rstn_i,          // device reset, low
  input  wire logic                 fetch_i,         // advance one instruction
  input  wire logic                 jump_i,          // load jump target
  input  wire logic [AW-1:0]        jump_addr_i,     // jump target
  input  wire logic                 pcl_wr_i,        // write counter low byte
  input  wire logic [7:0]           pcl_wdata_i,     // new low byte
  input  wire logic                 tblp_wr_i,       // write table pointer
  input  wire logic [7:0]           tblp_wdata_i,    // new pointer value
  input  wire logic                 tab_req_i,       // start table read
  input  wire pmem_pkg::tab_page_t  tab_page_i,      // current or last page
  input  wire logic [7:0]           tab_dst_i,       // destination register
  input  wire logic [7:0]           ee_rdata_i,      // eeprom read byte
  input  wire logic                 prog_serial_clock_pin_i, // link clock
  input  wire logic                 prog_serial_data_pin_i,  // link data in
  output logic                      prog_serial_data_pin_o,  // link data out
  output logic                      prog_serial_data_pin_oe_o, // drive enable
  output logic [13:0]               instr_o,         // fetched word
  output logic [AW-1:0]             pc_o,            // program counter
  output logic [7:0]                pc_low_o,        // counter low byte
  output logic [7:0]                table_pointer_o, // table pointer
  output logic [7:0]                table_high_byte_o, // table high byte
  output logic                      tab_busy_o,      // table read running
  output logic                      dm_wr_o,         // data memory write
  output logic [7:0]                dm_addr_o,       // data memory address
  output logic [7:0]                dm_wdata_o,      // data memory byte
  output logic                      ee_wr_o,         // eeprom write
  output logic [EE_AW-1:0]          ee_addr_o,       // eeprom address
  output logic [7:0]                ee_wdata_o,      // eeprom byte
  output logic                      shared_func_en_o // shared pin function on
);
  import pmem_pkg::*;
  localparam int PW = AW - `OFS_W;

  if (WORDS != `WORDS_SMALL && WORDS != `WORDS_LARGE)
  begin : g_bad_words
    $error("WORDS must be 1024 or 2048");
  end
  // eeprom address must fit the 12-bit link address
  if (EE_AW < 1 || EE_AW > 12)
  begin : g_bad_ee_aw
    $error("EE_AW out of range");
  end

  function automatic logic [AW-1:0] tab_addr(tab_page_t sel,
                                             logic [AW-1:0] pc,
                                             logic [7:0] ofs);
    logic [PW-1:0] pg;
    pg = (sel == PAGE_LAST) ? {PW{1'b1}} : pc[AW-1:`OFS_W];
    return {pg, ofs};
  endfunction

  logic [1:0] rs_reg;
  logic       rst_n;

  // reset enters asynchronously, leaves on two clock edges
  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      rs_reg <= 2'h0;
    else
      rs_reg <= {rs_reg[0], 1'b1};
  end
  assign rst_n = rs_reg[1];

  pmem_link_if lk ();
  logic [13:0] fdata, tdata, ldata;
  logic        sda_o, sda_oe;

  // one pin pair serves program store and eeprom access
  serial_link u_link (
    .clk_i    (sys_clk_i),
    .rstn_i   (rst_n),
    .sck_i    (prog_serial_clock_pin_i),
    .sda_i    (prog_serial_data_pin_i),
    .sda_o    (sda_o),
    .sda_oe_o (sda_oe),
    .lk       (lk)
  );

  logic [AW-1:0] pc_reg, pc_next;
  logic [AW-1:0] taddr_reg, taddr_next;

  prog_store #(.WORDS(WORDS), .AW(AW)) u_store (
    .clk_i   (sys_clk_i),
    .rstn_i  (rst_n),
    .we_i    (lk.wr_stb & ~lk.tgt),
    .waddr_i (lk.addr[AW-1:0]),
    .wdata_i (lk.wdata),
    .faddr_i (pc_reg),
    .taddr_i (taddr_reg),
    .laddr_i (lk.addr[AW-1:0]),
    .fdata_o (fdata),
    .tdata_o (tdata),
    .ldata_o (ldata)
  );

  assign lk.rd_data = lk.tgt ? {6'h00, ee_rdata_i} : ldata;

  tab_state_t  tst_reg, tst_next;
  logic [7:0]  tblp_reg, tblp_next;
  logic [7:0]  tbh_reg, tbh_next;
  logic [13:0] word_reg, word_next;
  logic [13:0] instr_reg, instr_next;
  logic        busy_reg, busy_next;
  logic        dmw_reg, dmw_next;
  logic [7:0]  dma_reg, dma_next, dst_reg, dst_next, dmd_reg, dmd_next;

  // program counter; held while a table read owns the cycles
  always_comb
  begin
    pc_next = pc_reg;
    if (tst_reg == TAB_IDLE)
    begin
      if (jump_i)
        pc_next = jump_addr_i;
      // low byte write stays in page
      else if (pcl_wr_i)
        pc_next = {pc_reg[AW-1:`OFS_W], pcl_wdata_i};
      else if (fetch_i)
        pc_next = pc_reg + AW'(1);
    end
    instr_next = fdata;
  end

  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pc_reg    <= AW'(`RESET_VEC);
      instr_reg <= 14'h0000;
    end
    else
    begin
      pc_reg    <= pc_next;
      instr_reg <= instr_next;
    end
  end

  // table engine: request, read word, write back; two busy cycles
  always_comb
  begin
    tst_next = tst_reg; taddr_next = taddr_reg; word_next = word_reg;
    tbh_next = tbh_reg; dst_next = dst_reg; dmw_next = 1'b0;
    dma_next = dma_reg; dmd_next = dmd_reg;
    tblp_next = tblp_wr_i ? tblp_wdata_i : tblp_reg;
    unique case (tst_reg)
      TAB_IDLE:
        if (tab_req_i)
        begin
          taddr_next = tab_addr(tab_page_i, pc_reg, tblp_reg);
          dst_next   = tab_dst_i;
          tst_next   = TAB_READ;
        end
      TAB_READ:
      begin
        word_next = tdata;
        tst_next  = TAB_WRITE;
      end
      TAB_WRITE:
      begin
        dmw_next = 1'b1;
        dma_next = dst_reg;
        dmd_next = word_reg[7:0];
        tbh_next = {{(`TBH_W - 6){1'b0}}, word_reg[13:8]};
        tst_next = TAB_IDLE;
      end
      default:
        tst_next = TAB_IDLE;
    endcase
    busy_next = (tst_next != TAB_IDLE);
  end

  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tst_reg <= TAB_IDLE; taddr_reg <= '0; word_reg <= 14'h0000;
      tblp_reg <= `TBLP_RST; tbh_reg <= 8'h00; dst_reg <= 8'h00;
      dmw_reg <= 1'b0; dma_reg <= 8'h00; dmd_reg <= 8'h00;
      busy_reg <= 1'b0;
    end
    else
    begin
      tst_reg <= tst_next; taddr_reg <= taddr_next; word_reg <= word_next;
      tblp_reg <= tblp_next; tbh_reg <= tbh_next; dst_reg <= dst_next;
      dmw_reg <= dmw_next; dma_reg <= dma_next; dmd_reg <= dmd_next;
      busy_reg <= busy_next;
    end
  end

  logic             eew_reg, eew_next, pin_reg, pin_next, oe_reg, oe_next;
  logic             shf_reg, shf_next;
  logic [EE_AW-1:0] eea_reg, eea_next;
  logic [7:0]       eed_reg, eed_next;

  // eeprom port and pin retiming; costs one cycle on the data pin
  always_comb
  begin
    eew_next = lk.wr_stb & lk.tgt;
    eea_next = lk.wr_stb ? lk.addr[EE_AW-1:0] : eea_reg;
    eed_next = lk.wr_stb ? lk.wdata[7:0] : eed_reg;
    pin_next = sda_o;
    oe_next  = sda_oe;
    // inert on emulation part or during a frame
    shf_next = !EMU_DEVICE && !lk.active;
  end

  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      eew_reg <= 1'b0; eea_reg <= '0; eed_reg <= 8'h00;
      pin_reg <= 1'b0; oe_reg <= 1'b0; shf_reg <= 1'b0;
    end
    else
    begin
      eew_reg <= eew_next; eea_reg <= eea_next; eed_reg <= eed_next;
      pin_reg <= pin_next; oe_reg <= oe_next; shf_reg <= shf_next;
    end
  end

  assign instr_o                   = instr_reg;
  assign pc_o                      = pc_reg;
  assign pc_low_o                  = pc_reg[7:0];
  assign table_pointer_o           = tblp_reg;
  assign table_high_byte_o         = tbh_reg;
  assign tab_busy_o                = busy_reg;
  assign dm_wr_o                   = dmw_reg;
  assign dm_addr_o                 = dma_reg;
  assign dm_wdata_o                = dmd_reg;
  assign ee_wr_o                   = eew_reg;
  assign ee_addr_o                 = eea_reg;
  assign ee_wdata_o                = eed_reg;
  assign prog_serial_data_pin_o    = pin_reg;
  assign prog_serial_data_pin_oe_o = oe_reg;
  assign shared_func_en_o          = shf_reg;

  // checks on the table engine, counter and shared function enable
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n);

  a_pc_reset_zero: assert property ($rose(rst_n) |-> pc_reg == '0)
    else $error("counter not zero after reset");
  a_tab_two_cycles: assert property (
    (tst_reg == TAB_IDLE && tab_req_i) |=> busy_reg [*2] ##1 !busy_reg)
    else $error("table read not two cycles");
  a_tab_low_byte: assert property ((tst_reg == TAB_WRITE) |=>
    dm_wr_o && dm_wdata_o == $past(word_reg[7:0]) && dm_addr_o == $past(dst_reg))
    else $error("low byte not written");
  a_tab_high_byte: assert property ((tst_reg == TAB_WRITE) |=>
    tbh_reg[5:0] == $past(word_reg[13:8]))
    else $error("high byte not loaded");
  a_tbh_upper_zero: assert property (tbh_reg[7:6] == 2'h0)
    else $error("unused high bits set");
  a_tbh_only_table: assert property (
    $past(tst_reg) != TAB_WRITE |-> $stable(tbh_reg))
    else $error("high byte changed outside table read");
  a_addr_current: assert property (
    (tst_reg == TAB_IDLE && tab_req_i && tab_page_i == PAGE_CURRENT) |=>
    taddr_reg == {$past(pc_reg[AW-1:`OFS_W]), $past(tblp_reg)})
    else $error("current page address wrong");
  a_addr_last: assert property (
    (tst_reg == TAB_IDLE && tab_req_i && tab_page_i == PAGE_LAST) |=>
    taddr_reg == {{PW{1'b1}}, $past(tblp_reg)})
    else $error("last page address wrong");
  a_pc_step: assert property (
    (tst_reg == TAB_IDLE && fetch_i && !jump_i && !pcl_wr_i) |=>
    pc_reg == $past(pc_reg) + AW'(1))
    else $error("counter did not step");
  a_shared_inert: assert property (
    (EMU_DEVICE || $past(lk.active)) |-> !shared_func_en_o)
    else $error("shared function active");

  c_tab_current: cover property (tab_req_i && tab_page_i == PAGE_CURRENT
    && tst_reg == TAB_IDLE ##3 dm_wr_o);
  c_tab_last: cover property (tab_req_i && tab_page_i == PAGE_LAST
    && tst_reg == TAB_IDLE ##3 dm_wr_o);
  c_prog_write: cover property (lk.wr_stb && !lk.tgt);
  c_ee_write: cover property (ee_wr_o);
endmodule // program_memory_table_read
`default_nettype wire

/* serial_link.sv */
// two-wire serial programming link, sampled on the system clock
`default_nettype none
`include "pmem_consts.svh"
module serial_link (
  input  wire logic  clk_i,    // system clock
  input  wire logic  rstn_i,   // synchronised reset, low
  input  wire logic  sck_i,    // link clock pin
  input  wire logic  sda_i,    // link data pin in
  output logic       sda_o,    // link data pin out
  output logic       sda_oe_o, // link data drive enable
  pmem_link_if.link  lk        // core side
);
  import pmem_pkg::*;
  localparam int IDLE_CYC = `LINK_IDLE_CYC;
  logic [1:0]  ck_s_reg, dt_s_reg;
  logic        ck_prev_reg;
  link_state_t st_reg, st_next;
  logic [4:0]  cnt_reg, cnt_next;
  logic [13:0] sh_reg, sh_next, ws;
  logic [11:0] adr_reg, adr_next;
  logic        tgt_reg, tgt_next, stb_reg, stb_next;
  logic        out_reg, out_next, oe_reg, oe_next;
  logic [7:0]  idle_reg, idle_next;
  logic        rise, fall;

  // pins are foreign to this clock, two flops before use
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      ck_s_reg    <= 2'h0;
      dt_s_reg    <= 2'h0;
      ck_prev_reg <= 1'b0;
    end
    else
    begin
      ck_s_reg    <= {ck_s_reg[0], sck_i};
      dt_s_reg    <= {dt_s_reg[0], sda_i};
      ck_prev_reg <= ck_s_reg[1];
    end
  end
  assign rise = ck_s_reg[1] & ~ck_prev_reg;
  assign fall = ~ck_s_reg[1] & ck_prev_reg;
  assign ws   = {sh_reg[12:0], dt_s_reg[1]};

  // one data pin, clocked
  // frame: op, target, 12 address bits, then 14 data bits in or out
  always_comb
  begin
    st_next = st_reg; cnt_next = cnt_reg; sh_next = sh_reg;
    adr_next = adr_reg; tgt_next = tgt_reg; stb_next = 1'b0;
    out_next = out_reg; oe_next = oe_reg;
    idle_next = (rise | fall) ? 8'h00 :
                (idle_reg == 8'(IDLE_CYC)) ? idle_reg : idle_reg + 8'h01;
    unique case (st_reg)
      LNK_CMD:
        if (rise)
        begin
          sh_next  = ws;
          cnt_next = cnt_reg + 5'h01;
          if (cnt_reg == 5'(`FRM_CMD_BITS - 1))
          begin
            cnt_next = 5'h00;
            tgt_next = ws[`FRM_TGT_BIT];
            adr_next = ws[`FRM_ADDR_W-1:0];
            st_next  = ws[`FRM_OP_BIT] ? LNK_WDATA : LNK_RDATA;
          end
        end
      LNK_WDATA:
        if (rise)
        begin
          sh_next  = ws;
          cnt_next = cnt_reg + 5'h01;
          if (cnt_reg == 5'(`FRM_DAT_BITS - 1))
          begin
            stb_next = 1'b1;
            cnt_next = 5'h00;
            st_next  = LNK_CMD;
          end
        end
      LNK_RDATA:
        if (fall)
        begin
          if (cnt_reg == 5'(`FRM_DAT_BITS))
          begin
            oe_next  = 1'b0;
            cnt_next = 5'h00;
            st_next  = LNK_CMD;
          end
          else
          begin
            sh_next  = (cnt_reg == 5'h00) ? lk.rd_data : {sh_reg[12:0], 1'b0};
            out_next = (cnt_reg == 5'h00) ? lk.rd_data[13] : sh_reg[12];
            oe_next  = 1'b1;
            cnt_next = cnt_reg + 5'h01;
          end
        end
      default:
        st_next = LNK_CMD;
    endcase
    // a stopped clock abandons the frame; an edge seen now opens the next one
    // instead, so the first bit after a long idle is not thrown away
    if (idle_reg == 8'(IDLE_CYC) && !(rise | fall))
    begin
      st_next = LNK_CMD; cnt_next = 5'h00; oe_next = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      st_reg <= LNK_CMD; cnt_reg <= 5'h00; sh_reg <= 14'h0000;
      adr_reg <= 12'h000; tgt_reg <= 1'b0; stb_reg <= 1'b0;
      out_reg <= 1'b0; oe_reg <= 1'b0; idle_reg <= 8'h00;
    end
    else
    begin
      st_reg <= st_next; cnt_reg <= cnt_next; sh_reg <= sh_next;
      adr_reg <= adr_next; tgt_reg <= tgt_next; stb_reg <= stb_next;
      out_reg <= out_next; oe_reg <= oe_next; idle_reg <= idle_next;
    end
  end

  assign lk.wr_stb = stb_reg;
  assign lk.tgt    = tgt_reg;
  assign lk.addr   = adr_reg;
  assign lk.wdata  = sh_reg;
  assign lk.active = (st_reg != LNK_CMD) || (cnt_reg != 5'h00);
  assign sda_o     = out_reg;
  assign sda_oe_o  = oe_reg;

  a_oe_read_only: assert property (@(posedge clk_i) disable iff (!rstn_i)
    oe_reg |-> st_reg == LNK_RDATA) else $error("link drives outside read");
endmodule // serial_link
`default_nettype wire

/* testbench.sv */
// self-checking bench for the program memory and table read block
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import pmem_pkg::*;
  localparam logic [13:0] W1 = 14'h2a5b;
  localparam logic [13:0] W2 = 14'h15c3;
  localparam logic [13:0] W3 = 14'h3f1a;
  logic        clk = 1'b0, rstn = 1'b0, fetch = 1'b0, jump = 1'b0;
  logic        pcl_wr = 1'b0, tblp_wr = 1'b0, tab_req = 1'b0;
  logic [9:0]  jaddr = 10'h000;
  logic [7:0]  pcl_d = 8'h00, tblp_d = 8'h00, dst = 8'h00;
  tab_page_t   page = PAGE_CURRENT;
  wire logic   sck, drv, dat, line;
  logic        sda_o, sda_oe, busy, dm_wr, ee_wr, sfe;
  logic [13:0] instr, q;
  logic [9:0]  pc;
  logic [7:0]  pc_low_reg, tptr, tbh, dm_a, dm_d, ee_d, ee_sd;
  logic [5:0]  ee_a, ee_sa;
  int          num_errors = 0, n_tests = 0, ee_n = 0;

  always #5 clk = ~clk;
  // pull-up wins when neither side drives the pin
  assign line = sda_oe ? sda_o : (drv ? dat : 1'b1);

  program_memory_table_read #(.WORDS(1024)) DUT (
    .sys_clk_i(clk), .rstn_i(rstn), .fetch_i(fetch), .jump_i(jump),
    .jump_addr_i(jaddr), .pcl_wr_i(pcl_wr), .pcl_wdata_i(pcl_d),
    .tblp_wr_i(tblp_wr), .tblp_wdata_i(tblp_d), .tab_req_i(tab_req),
    .tab_page_i(page), .tab_dst_i(dst), .ee_rdata_i(8'ha5),
    .prog_serial_clock_pin_i(sck), .prog_serial_data_pin_i(line),
    .prog_serial_data_pin_o(sda_o), .prog_serial_data_pin_oe_o(sda_oe),
    .instr_o(instr), .pc_o(pc), .pc_low_o(pc_low_reg), .table_pointer_o(tptr),
    .table_high_byte_o(tbh), .tab_busy_o(busy), .dm_wr_o(dm_wr),
    .dm_addr_o(dm_a), .dm_wdata_o(dm_d), .ee_wr_o(ee_wr), .ee_addr_o(ee_a),
    .ee_wdata_o(ee_d), .shared_func_en_o(sfe));

  link_host host (.sck_o(sck), .drv_o(drv), .dat_o(dat), .line_i(line));

  // catch the one-cycle eeprom strobe where it has settled
  always @(negedge clk)
    if (ee_wr === 1'b1)
    begin
      ee_n++;
      ee_sa = ee_a;
      ee_sd = ee_d;
    end

  task automatic check(input string what, input logic [13:0] got, input logic [13:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic test_reset();
    repeat (3) @(negedge clk);
    rstn = 1'b1;
    repeat (4) @(negedge clk);
    check("pc", pc, 10'h000);
    check("pointer", tptr, 8'h00);
    check("high byte", tbh, 8'h00);
    check("busy", busy, 1'b0);
    check("shared pins", sfe, 1'b1);
    check("pin drive", sda_oe, 1'b0);
    $display("done reset");
  endtask

  task automatic test_link();
    // shared pin functions must stay idle while a frame runs
    fork
      host.frame(1'b1, 1'b0, 12'h105, W1, q);
      #2000 check("shared in frame", sfe, 1'b0);
    join
    host.frame(1'b1, 1'b0, 12'h106, W2, q);
    host.frame(1'b1, 1'b0, 12'h306, W3, q);
    host.frame(1'b1, 1'b1, 12'h02a, 14'h0077, q);
    check("ee strobes", ee_n, 14'd1);
    check("ee addr", ee_sa, 6'h2a);
    check("ee data", ee_sd, 8'h77);
    host.frame(1'b0, 1'b0, 12'h306, 14'h0000, q);
    check("store read", q, W3);
    host.frame(1'b0, 1'b1, 12'h02a, 14'h0000, q);
    check("ee read", q, 14'h00a5);
    check("pin released", sda_oe, 1'b0);
    $display("done link");
  endtask

  task automatic test_fetch();
    @(negedge clk);
    jump = 1'b1;
    jaddr = 10'h106;
    @(negedge clk);
    jump = 1'b0;
    check("pc jump", pc, 10'h106);
    @(negedge clk);
    check("fetched", instr, W2);
    $display("done fetch");
  endtask

  task automatic test_tab(input tab_page_t pg, input logic [7:0] ptr, input logic [13:0] w);
    // no interrupt model, so table reads never overlap
    @(negedge clk);
    tblp_wr = 1'b1;
    tblp_d = ptr;
    @(negedge clk);
    tblp_wr = 1'b0;
    tab_req = 1'b1;
    page = pg;
    dst = ptr + 8'h40;
    @(negedge clk);
    tab_req = 1'b0;
    check("pointer", tptr, ptr);
    check("busy 1", busy, 1'b1);
    @(negedge clk);
    check("busy 2", busy, 1'b1);
    @(negedge clk);
    check("busy end", busy, 1'b0);
    check("dm strobe", dm_wr, 1'b1);
    check("dm addr", dm_a, ptr + 8'h40);
    check("dm byte", dm_d, w[7:0]);
    check("high byte", tbh, {2'b00, w[13:8]});
    $display("done table read");
  endtask

  task automatic test_hold();
    pcl_wr = 1'b1;
    pcl_d = 8'h20;
    @(negedge clk);
    pcl_wr = 1'b0;
    fetch = 1'b1;
    check("dm strobe off", dm_wr, 1'b0);
    check("pc low write", pc, 10'h120);
    check("pc low", pc_low_reg, 8'h20);
    @(negedge clk);
    fetch = 1'b0;
    check("pc step", pc, 10'h121);
    check("high byte kept", tbh, {2'b00, W3[13:8]});
    $display("done hold");
  endtask

  // watchdog: the whole sequence needs about 35 us
  initial
  begin
    #300us;
    num_errors++;
    end_of_test();
  end

  initial
  begin
    test_reset();
    test_link();
    test_fetch();
    test_tab(PAGE_CURRENT, 8'h05, W1);
    test_tab(PAGE_LAST, 8'h06, W3);
    test_hold();
    end_of_test();
  end
endmodule // testbench
`default_nettype wire
